/* File: logic_simulation_stimulus_player_tb.sv */
// logic_simulation_stimulus_player_tb: self-checking bench of the stimulus player
// assumes lsp_player with 8 steps and code 2 (5-cycle step period)
`timescale 1ns/10ps
`include "lsp_defs.svh"
module logic_simulation_stimulus_player_tb;
   logic                              ref_clk = 1'b0;
   logic                              reset = 1'b1;
   logic                              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]                        paddr = 8'h00;
   logic [31:0]                       pwdata = 32'h0, prdata, rd, s;
   logic                              pready, pslverr, serr;
   logic [11:0]                       pins = 12'h000, logic_in, x;
   logic                              logic_en, logic_run, cpu_irq, enc_frame;
   logic                              user_irq = 1'b1, enc_frame_req = 1'b1;
   lsp_pkg::lsp_res_t                 term_in;
   lsp_pkg::lsp_elem_t [7:0][1:0]     units = '0;
   logic [7:0]                        se_out;
   logic [5:0]                        dif_out;
   int                                err_count = 0, check_count = 0;

   lsp_player #(.P_CYC_1MS(18'h00014), .P_CYC_100US(18'h0000A), .STEPS(8)) u_dut (
      .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_input_points(pins), .logic_in(logic_in), .logic_en(logic_en),
      .logic_run(logic_run), .term_in(term_in), .multi_function_counter_units(units),
      .ctr_mode32(8'h01), .single_ended_output_points(se_out),
      .differential_output_points(dif_out), .user_irq(user_irq), .cpu_irq(cpu_irq),
      .enc_frame_req(enc_frame_req), .enc_frame(enc_frame));

   lsp_user_model u_user (.logic_in(logic_in), .term_in(term_in));

   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; holds the request until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         err_count++;
         end_of_test;
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task t_regs;
      int c;
      apb(0, `LSP_A_STEP, 0); chk(rd[3:0], `LSP_STEP_RST);
      apb(0, 8'h30, 0);
      chk(serr, 1'b1);
      chk(rd, 32'h0);
      for (c = 2; c <= 8; c++) begin
         apb(1, `LSP_A_STEP, c); apb(0, `LSP_A_STEP, 0); chk(rd[3:0], c);
      end
      apb(1, `LSP_A_STEP, 32'h9); apb(0, `LSP_A_STEP, 0); chk(rd[3:0], 4'h8);
      apb(1, `LSP_A_STEP, `LSP_CODE_25NS);
      apb(1, `LSP_A_CTRL, 32'h1); apb(0, `LSP_A_STAT, 0); chk(rd[4:0], 5'h10);
      apb(1, `LSP_A_CTRL, 32'h8);
      $display("regs test done");
   endtask

   task t_obs;
      units[1][1].cnt <= 32'h0000ABCD;
      units[0][1].cnt <= 32'h00001234;
      pins <= 12'h123;
      apb(1, `LSP_A_CTRL, 32'h2);
      apb(0, `LSP_A_OBSA, 0); chk(rd[27:0], {8'h23, 8'h12, 12'h123});
      apb(0, `LSP_A_OBSB, 0); chk(rd[5:0], 6'h23);
      apb(1, `LSP_A_OSEL, 32'h10); apb(0, `LSP_A_OCNT, 0); chk(rd, 32'h0);
      apb(1, `LSP_A_OSEL, 32'h11); apb(0, `LSP_A_OCNT, 0); chk(rd, 32'hABCD);
      chk({cpu_irq, enc_frame}, 2'b11);
      apb(1, `LSP_A_CTRL, 32'h4);
      pins <= 12'h456;
      apb(0, `LSP_A_OBSA, 0); chk(rd[27:0], {8'h23, 8'h12, 12'h123});
      $display("observation test done");
   endtask

   task t_run;
      int i, k;
      logic [11:0] v;
      apb(1, `LSP_A_TADR, 0);
      for (i = 0; i < 8; i++) apb(1, `LSP_A_TDAT, 12'h5A0 + i * 12'h111);
      apb(1, `LSP_A_CTRL, 32'h2);
      apb(1, `LSP_A_CTRL, 32'h1);
      // control flags change on the edge that ended the write; look once settled
      #1 chk({logic_run, logic_en}, 2'b01);
      @(posedge ref_clk) #1 x = logic_in;
      @(posedge ref_clk) #1 chk(se_out, x[7:0]);
      chk(dif_out, x[5:0]);
      chk({cpu_irq, enc_frame}, 2'b00);
      k = 0;
      for (i = 0; i < 400; i++) begin
         apb(0, `LSP_A_STAT, 0);
         s = rd;
         if (s[5]) begin
            // expected word follows the stand-in user logic wiring of step k
            v = 12'h5A0 + 12'(k) * 12'h111;
            apb(0, `LSP_A_RESL, 0);
            chk(rd, {v[3:0], v[7:0], v[11:4], v});
            chk(rd[11:0], v);
            apb(0, `LSP_A_RESH, 0);
            chk(rd[31], 1'b1);
            chk(rd[1:0], v[5:4]);
            k++;
         end else if (s[1]) break;
      end
      if (i == 400) begin
         err_count++;
         end_of_test;
      end
      chk(k, 8);
      chk(s[2:0], 3'b010);
      pins <= 12'h3C3;
      apb(0, `LSP_A_STAT, 0);
      chk({logic_run, logic_in}, {1'b0, 12'h3C3});
      $display("run test done");
   endtask

   // reset for 16 cycles, then the scenarios in turn
   initial begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_obs;
      t_run;
      end_of_test;
   end
endmodule

/* File: lsp_defs.svh */
// lsp_defs.svh: register map, field positions, reset values and step timing of the player
// assumes a 200 MHz ref_clk and a 32-bit APB slave with byte addresses on paddr
// Function
// - table of 12 input bits by 2048 steps, 0 inactive, 1 active
// - while running, table steps replace the input pins, one step per period; a full result buffer stalls the step until the host reads
// - one result sample taken per step period, aligned with the step advance
// - table kept until power loss; host loads it before starting a run
// - output pins keep following the user logic during a run
// - interrupt requests to the host are suppressed during a run
// - no encoder frames during a run; encoder data never enters results
// - observed values frozen while user logic is stopped; last values readable
// - observation shows inputs, counter outputs, output block inputs, counter states
// - second counter element hidden when its unit runs in 32-bit mode
// - step period codes 8..2 select 1 ms down to 25 ns
// - run start stops user logic control; it stays stopped until restarted
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH
// register byte offsets
`define LSP_A_CTRL 8'h00
`define LSP_A_STEP 8'h04
`define LSP_A_STAT 8'h08
`define LSP_A_TADR 8'h0C
`define LSP_A_TDAT 8'h10
`define LSP_A_RESL 8'h14
`define LSP_A_RESH 8'h18
`define LSP_A_OBSA 8'h1C
`define LSP_A_OBSB 8'h20
`define LSP_A_OSEL 8'h24
`define LSP_A_OCNT 8'h28
`define LSP_A_OACT 8'h2C
// control bits, write one to act
`define LSP_CTRL_START 0
`define LSP_CTRL_LGO 1
`define LSP_CTRL_LSTOP 2
`define LSP_CTRL_CLR 3
// status bits
`define LSP_ST_RUN 0
`define LSP_ST_DONE 1
`define LSP_ST_LOGIC 2
`define LSP_ST_LOADED 3
`define LSP_ST_ERR 4
`define LSP_ST_RESV 5
`define LSP_ST_IDX 16
// select fields
`define LSP_OSEL_ELEM 4
`define LSP_OACT_M32 8
// reset values
`define LSP_STEP_RST 4'h8
`define LSP_OSEL_RST 5'h00
// sizes
`define LSP_STEPS 2048
`define LSP_FIFO_DEPTH 4
// step codes
`define LSP_CODE_1MS 4'h8
`define LSP_CODE_100US 4'h7
`define LSP_CODE_10US 4'h6
`define LSP_CODE_1US 4'h5
`define LSP_CODE_100NS 4'h4
`define LSP_CODE_50NS 4'h3
`define LSP_CODE_25NS 4'h2
// step times, each in its own unit, and the clock period in ns
`define LSP_CLK_NS 5
`define LSP_T_1MS_MS 1
`define LSP_T_100US_US 100
`define LSP_T_10US_US 10
`define LSP_T_1US_US 1
`define LSP_T_100NS_NS 100
`define LSP_T_50NS_NS 50
`define LSP_T_25NS_NS 25
// step periods in ref_clk cycles
`define LSP_CYC_1MS ((`LSP_T_1MS_MS * 1000000) / `LSP_CLK_NS)
`define LSP_CYC_100US ((`LSP_T_100US_US * 1000) / `LSP_CLK_NS)
`define LSP_CYC_10US ((`LSP_T_10US_US * 1000) / `LSP_CLK_NS)
`define LSP_CYC_1US ((`LSP_T_1US_US * 1000) / `LSP_CLK_NS)
`define LSP_CYC_100NS (`LSP_T_100NS_NS / `LSP_CLK_NS)
`define LSP_CYC_50NS (`LSP_T_50NS_NS / `LSP_CLK_NS)
`define LSP_CYC_25NS (`LSP_T_25NS_NS / `LSP_CLK_NS)
`endif

/* File: lsp_fifo.sv */
// lsp_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset, depth a power of two
`timescale 1ns/10ps
module lsp_fifo #(
   parameter int W = 34,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
      $error("lsp_fifo depth must be a power of two of at least 2");
   end
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // full and empty come straight from the fill count
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q];

   // storage has no reset; contents only matter once counted
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

/* File: lsp_pkg.sv */
// lsp_pkg: types shared by the stimulus player and its stand-in user logic
// assumes lsp_defs.svh sits in the same folder
package lsp_pkg;
   // run state of the player
   typedef enum logic [1:0] {
      LSP_IDLE = 2'b00,
      LSP_RUN  = 2'b01
   } lsp_state_t;
   // one step's terminal states; also the result word
   typedef struct packed {
      logic [5:0]  dif;
      logic [7:0]  se;
      logic [7:0]  ctr;
      logic [11:0] inb;
   } lsp_res_t;
   // one counter-timer element as observed
   typedef struct packed {
      logic [4:0]  act;
      logic [31:0] cnt;
   } lsp_elem_t;
endpackage

/* File: lsp_player.sv */
// lsp_player: logic simulation stimulus player with result capture and observation
// assumes an APB master on ref_clk and user logic that takes logic_in and logic_en
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "lsp_defs.svh"
module lsp_player #(
   parameter logic [17:0] P_CYC_1MS   = 18'(`LSP_CYC_1MS),
   parameter logic [17:0] P_CYC_100US = 18'(`LSP_CYC_100US),
   parameter int          STEPS       = `LSP_STEPS,
   parameter int          FIFO_DEPTH  = `LSP_FIFO_DEPTH
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [11:0]           external_input_points,
   output logic [11:0]                logic_in,
   output logic                       logic_en,
   output logic                       logic_run,
   input  wire lsp_pkg::lsp_res_t     term_in,
   input  wire lsp_pkg::lsp_elem_t [7:0][1:0] multi_function_counter_units,
   input  wire logic [7:0]            ctr_mode32,
   output logic [7:0]                 single_ended_output_points,
   output logic [5:0]                 differential_output_points,
   input  wire logic                  user_irq,
   output logic                       cpu_irq,
   input  wire logic                  enc_frame_req,
   output logic                       enc_frame
);
   localparam int IW = $clog2(STEPS);
   localparam int RW = $bits(lsp_pkg::lsp_res_t);
   if (STEPS < 2 || STEPS > `LSP_STEPS) begin : g_chk
      $error("lsp_player steps must lie between 2 and the table size");
   end

   lsp_pkg::lsp_state_t state_q;
   logic [11:0]   tbl [STEPS];
   logic [11:0]   stim_q;
   logic [IW-1:0] idx_q;
   logic [IW-1:0] tadr_q;
   logic [17:0]   tmr_q;
   logic [17:0]   per_q;
   logic [3:0]    step_q;
   logic [4:0]    osel_q;
   logic          loaded_q;
   logic          done_q;
   logic          err_q;
   logic          logic_run_q;
   logic          running;
   logic          wr;
   logic          rd_acc;
   logic          setup;
   logic          start_req;
   logic          start_ok;
   logic          tick;
   logic          last;
   logic          res_ready;
   logic          res_valid;
   logic          res_pop;
   logic          m32_hide;
   lsp_pkg::lsp_res_t  res_data;
   lsp_pkg::lsp_res_t  obs_q;
   lsp_pkg::lsp_elem_t [7:0][1:0] octr_q;
   lsp_pkg::lsp_elem_t osel_elem;
   logic [31:0]   rd_mux;
   logic          rd_err;

   // step period lookup; unused codes map to zero and are refused on write
   function automatic logic [17:0] period_of(input logic [3:0] code);
      logic [17:0] p;
      p = '0;
      case (code)
         `LSP_CODE_1MS:   p = P_CYC_1MS;
         `LSP_CODE_100US: p = P_CYC_100US;
         `LSP_CODE_10US:  p = 18'(`LSP_CYC_10US);
         `LSP_CODE_1US:   p = 18'(`LSP_CYC_1US);
         `LSP_CODE_100NS: p = 18'(`LSP_CYC_100NS);
         `LSP_CODE_50NS:  p = 18'(`LSP_CYC_50NS);
         `LSP_CODE_25NS:  p = 18'(`LSP_CYC_25NS);
         default:         p = '0;
      endcase
      return p;
   endfunction

   // apb decode: zero wait states, read data built in the setup cycle
   assign pready    = 1'b1;
   assign setup     = psel && !penable;
   assign wr        = psel && penable && pwrite;
   assign rd_acc    = psel && penable && !pwrite;
   assign running   = (state_q == lsp_pkg::LSP_RUN);
   assign start_req = wr && (paddr == `LSP_A_CTRL) && pwdata[`LSP_CTRL_START] && !running;
   assign start_ok  = start_req && loaded_q;
   assign last      = (idx_q == IW'(STEPS - 1));
   // sample per step; a full buffer stalls the step instead of dropping it
   assign tick      = running && (tmr_q == '0) && res_ready;
   assign res_pop   = rd_acc && (paddr == `LSP_A_RESH);

   // run state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= lsp_pkg::LSP_IDLE;
      end else begin
         unique case (state_q)
            lsp_pkg::LSP_IDLE: begin
               if (start_ok) begin
                  state_q <= lsp_pkg::LSP_RUN;
               end
            end
            lsp_pkg::LSP_RUN: begin
               if (tick && last) begin
                  state_q <= lsp_pkg::LSP_IDLE;
               end
            end
            default: state_q <= lsp_pkg::LSP_IDLE;
         endcase
      end
   end

   // step timer; period frozen at start so a mid-run code write cannot tear a step
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tmr_q <= '0;
         per_q <= '0;
      end else if (start_ok) begin
         per_q <= period_of(step_q) - 18'h00001;
         tmr_q <= period_of(step_q) - 18'h00001;
      end else if (running) begin
         if (tmr_q != '0) begin
            tmr_q <= tmr_q - 18'h00001;
         end else if (tick) begin
            tmr_q <= per_q;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         idx_q <= '0;
      end else if (start_ok) begin
         idx_q <= '0;
      end else if (tick && !last) begin
         idx_q <= idx_q + 1'b1;
      end
   end

   // table storage; no reset, it holds until power goes
   always_ff @(posedge ref_clk) begin
      if (wr && (paddr == `LSP_A_TDAT) && !running) begin
         tbl[tadr_q] <= pwdata[11:0];
      end
      stim_q <= tbl[idx_q];
   end

   // table address, auto-incremented by each data write made outside a run
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tadr_q <= '0;
      end else if (wr && (paddr == `LSP_A_TADR)) begin
         tadr_q <= pwdata[IW-1:0];
      end else if (wr && (paddr == `LSP_A_TDAT) && !running) begin
         tadr_q <= tadr_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         loaded_q <= 1'b0;
      end else if (wr && (paddr == `LSP_A_TDAT) && !running) begin
         loaded_q <= 1'b1;
      end
   end

   // completion and refused-start flags; a new event beats a same-cycle clear
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         done_q <= 1'b0;
         err_q  <= 1'b0;
      end else begin
         if (tick && last) begin
            done_q <= 1'b1;
         end else if (wr && (paddr == `LSP_A_CTRL) && pwdata[`LSP_CTRL_CLR]) begin
            done_q <= 1'b0;
         end
         if (start_req && !loaded_q) begin
            err_q <= 1'b1;
         end else if (wr && (paddr == `LSP_A_CTRL) && pwdata[`LSP_CTRL_CLR]) begin
            err_q <= 1'b0;
         end
      end
   end

   // user logic control; a start request during a run is ignored
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         logic_run_q <= 1'b0;
      end else if (start_ok) begin
         logic_run_q <= 1'b0;
      end else if (wr && (paddr == `LSP_A_CTRL) && pwdata[`LSP_CTRL_LSTOP]) begin
         logic_run_q <= 1'b0;
      end else if (wr && (paddr == `LSP_A_CTRL) && pwdata[`LSP_CTRL_LGO] && !running) begin
         logic_run_q <= 1'b1;
      end
   end

   // user logic executes under control or under a run
   assign logic_run = logic_run_q;
   assign logic_en  = logic_run_q || running;
   assign logic_in  = running ? stim_q : external_input_points;

   // side effects on real pins and host paths
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         single_ended_output_points <= '0;
         differential_output_points <= '0;
         cpu_irq                    <= 1'b0;
         enc_frame                  <= 1'b0;
      end else begin
         single_ended_output_points <= term_in.se;
         differential_output_points <= term_in.dif;
         cpu_irq   <= user_irq && !running && !start_ok;
         enc_frame <= enc_frame_req && !running && !start_ok;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         obs_q  <= '0;
         octr_q <= '0;
      end else if (logic_en) begin
         obs_q  <= term_in;
         octr_q <= multi_function_counter_units;
      end
   end

   // observation select and step code registers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         osel_q <= `LSP_OSEL_RST;
         step_q <= `LSP_STEP_RST;
      end else begin
         if (wr && (paddr == `LSP_A_OSEL)) begin
            osel_q <= pwdata[4:0];
         end
         if (wr && (paddr == `LSP_A_STEP) && (period_of(pwdata[3:0]) != '0)) begin
            step_q <= pwdata[3:0];
         end
      end
   end

   // result buffer; the host drains it while the run goes on
   lsp_fifo #(
      .W (RW),
      .D (FIFO_DEPTH)
   ) u_res (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (tick),
      .in_ready  (res_ready),
      .in_data   (term_in),
      .out_valid (res_valid),
      .out_ready (res_pop),
      .out_data  (res_data)
   );

   // hide second element in 32-bit mode
   assign osel_elem = octr_q[osel_q[2:0]][osel_q[`LSP_OSEL_ELEM]];
   assign m32_hide  = osel_q[`LSP_OSEL_ELEM] && ctr_mode32[osel_q[2:0]];

   // read mux; unmapped offsets answer zero with an error
   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      unique case (paddr)
         `LSP_A_CTRL: rd_mux = '0;
         `LSP_A_STEP: rd_mux[3:0] = step_q;
         `LSP_A_STAT: begin
            rd_mux[`LSP_ST_RUN]    = running;
            rd_mux[`LSP_ST_DONE]   = done_q;
            rd_mux[`LSP_ST_LOGIC]  = logic_run_q;
            rd_mux[`LSP_ST_LOADED] = loaded_q;
            rd_mux[`LSP_ST_ERR]    = err_q;
            rd_mux[`LSP_ST_RESV]   = res_valid;
            rd_mux[`LSP_ST_IDX +: IW] = idx_q;
         end
         `LSP_A_TADR: rd_mux[IW-1:0] = tadr_q;
         `LSP_A_TDAT: rd_mux[11:0] = tbl[tadr_q];
         `LSP_A_RESL: rd_mux = res_data[31:0];
         `LSP_A_RESH: rd_mux = {res_valid, 29'h00000000, res_data[RW-1:32]};
         `LSP_A_OBSA: rd_mux = {4'h0, obs_q.se, obs_q.ctr, obs_q.inb};
         `LSP_A_OBSB: rd_mux[5:0] = obs_q.dif;
         `LSP_A_OSEL: rd_mux[4:0] = osel_q;
         `LSP_A_OCNT: rd_mux = m32_hide ? 32'h00000000 : osel_elem.cnt;
         `LSP_A_OACT: begin
            rd_mux[4:0] = m32_hide ? 5'h00 : osel_elem.act;
            rd_mux[`LSP_OACT_M32] = ctr_mode32[osel_q[2:0]];
         end
         default: rd_err = 1'b1;
      endcase
   end

   // apb answer registered in the setup cycle, valid through the access
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= rd_err;
      end
   end

   // checks
   sequence s_last_tick;
      tick && last;
   endsequence
   sequence s_start;
      start_ok;
   endsequence

   property p_stop_ctl;
      @(posedge ref_clk) disable iff (reset) s_start |=> !logic_run ##0 running;
   endproperty
   a_stop_ctl: assert property (p_stop_ctl) else $error("run did not stop control");

   property p_no_irq;
      @(posedge ref_clk) disable iff (reset) running |=> !cpu_irq;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("irq during run");

   property p_no_enc;
      @(posedge ref_clk) disable iff (reset) running |=> !enc_frame;
   endproperty
   a_no_enc: assert property (p_no_enc) else $error("encoder frame during run");

   property p_advance;
      @(posedge ref_clk) disable iff (reset) tick && !last |=> idx_q == $past(idx_q) + 1'b1;
   endproperty
   a_advance: assert property (p_advance) else $error("step did not advance");

   property p_spacing;
      @(posedge ref_clk) disable iff (reset) tick |=> !tick [*4];
   endproperty
   a_spacing: assert property (p_spacing) else $error("step period under 25 ns");

   property p_end;
      @(posedge ref_clk) disable iff (reset) s_last_tick |=> !running && done_q;
   endproperty
   a_end: assert property (p_end) else $error("run did not end after last step");

   property p_pins_back;
      @(posedge ref_clk) disable iff (reset) s_last_tick |=> logic_in == external_input_points;
   endproperty
   a_pins_back: assert property (p_pins_back) else $error("inputs not returned");

   property p_unloaded;
      @(posedge ref_clk) disable iff (reset) start_req && !loaded_q |=> !running ##0 err_q;
   endproperty
   a_unloaded: assert property (p_unloaded) else $error("run started unloaded");

   property p_freeze;
      @(posedge ref_clk) disable iff (reset) !logic_en |=> obs_q == $past(obs_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("observation moved while stopped");

   property p_outs;
      @(posedge ref_clk) disable iff (reset)
         1'b1 |=> single_ended_output_points == $past(term_in.se);
   endproperty
   a_outs: assert property (p_outs) else $error("outputs not driven");

   property p_hide;
      @(posedge ref_clk) disable iff (reset)
         setup && !pwrite && paddr == `LSP_A_OCNT && m32_hide |=> prdata == 32'h00000000;
   endproperty
   a_hide: assert property (p_hide) else $error("hidden element visible");
endmodule

/* File: lsp_user_model.sv */
// lsp_user_model: stand-in for the configured user logic behind the player
// assumes the player feeds logic_in; terminals answer combinationally
`timescale 1ns/10ps
module lsp_user_model (
   input  wire logic [11:0]   logic_in,
   output lsp_pkg::lsp_res_t  term_in
);
   // terminals keep following the inputs even when stopped, so a frozen
   // observation snapshot shows up as a difference
   assign term_in.inb = logic_in;
   assign term_in.ctr = logic_in[11:4];
   assign term_in.se  = logic_in[7:0];
   assign term_in.dif = logic_in[5:0];
endmodule
